// *** pkg/auto_restart_cfg.svh ***
// Constants for the automatic restart sequencer: codes, reset values, timing.
`ifndef AUTO_RESTART_CFG_SVH
`define AUTO_RESTART_CFG_SVH

// Restart mode codes.
`define ARS_MODE_OFF        8'h00
`define ARS_MODE_ACK_ONLY   8'h01
`define ARS_MODE_PF_RESTART 8'h04
`define ARS_MODE_FLT_RESTART 8'h06
`define ARS_MODE_PF_MANUAL  8'h0E
`define ARS_MODE_FLT_MANUAL 8'h10
`define ARS_MODE_ACK_ALL_ON 8'h1A

// Reset values of the settings.
`define ARS_RST_MODE        8'h00
`define ARS_RST_LIMIT       8'h03
`define ARS_RST_WAIT_TENTHS 16'h000A
`define ARS_RST_MON_SEC     16'h003C
`define ARS_RST_CNT_RST_SEC 16'h0000

// Timing: clock rate and the timebase steps.
`define ARS_CLK_HZ          25000000
`define ARS_TENTH_MS        100
`define ARS_TENTH_CYCLES    ((`ARS_CLK_HZ / 1000) * `ARS_TENTH_MS)
`define ARS_TENTHS_PER_SEC  4'hA
`define ARS_CONFIRM_TENTHS  16'h000A

`endif

// *** pkg/auto_restart_pkg.sv ***
// Types shared by the automatic restart sequencer and its timebase.
`default_nettype none
package auto_restart_pkg;

  // Sequencer states.
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_ACK,
    ST_WAIT,
    ST_START,
    ST_CONFIRM,
    ST_RUN,
    ST_FAILED
  } seq_state_e;

  // Settings held by the sequencer.
  typedef struct packed
  {
    logic [7:0]  mode;          // Automatic restart mode.
    logic [7:0]  limit;         // Start attempt limit n.
    logic [15:0] wait_tenths;   // Start wait time in 0.1 s steps.
    logic [15:0] mon_sec;       // Restart monitor time, seconds.
    logic [15:0] cnt_rst_sec;   // Counter-reset monitor time, seconds.
  } cfg_s;

  // Status shown to the control core.
  typedef struct packed
  {
    seq_state_e  state;         // Present sequencer state.
    logic [7:0]  attempts_left; // Internal start attempt counter.
    logic        mode_valid;    // Stored mode is a known code.
    logic        monitor_run;   // Restart monitor timer running.
  } status_s;

endpackage : auto_restart_pkg
`default_nettype wire

// *** hw/ars_timebase.sv ***
// Free-running tenth-second and one-second tick generator.
`include "auto_restart_cfg.svh"
`default_nettype none
module ars_timebase
  import auto_restart_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = 2500000
)
(
  // Clock and reset.
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  // Tick outputs.
  output logic      tick_tenth_o,
  output logic      tick_sec_o
);

  // Cycle counter inside one tenth of a second.
  logic [23:0] cyc_r;
  // Tenth counter inside one second.
  logic [3:0]  tenth_r;
  // Last cycle of a tenth.
  logic        tenth_end;

  assign tenth_end = (cyc_r == 24'(TENTH_CYCLES - 1));

  // Cycle divider; it never stops, so all intervals share one phase.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cyc_r <= 24'h000000;
    end
    else if (tenth_end)
    begin
      cyc_r <= 24'h000000;
    end
    else
    begin
      cyc_r <= cyc_r + 24'h000001;
    end
  end

  // Tenth divider and the registered tick pulses.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tenth_r      <= 4'h0;
      tick_tenth_o <= 1'b0;
      tick_sec_o   <= 1'b0;
    end
    else
    begin
      tick_tenth_o <= tenth_end;
      tick_sec_o   <= 1'b0;
      if (tenth_end)
      begin
        if (tenth_r == `ARS_TENTHS_PER_SEC - 4'h1)
        begin
          tenth_r    <= 4'h0;
          tick_sec_o <= 1'b1;
        end
        else
        begin
          tenth_r <= tenth_r + 4'h1;
        end
      end
    end
  end

endmodule : ars_timebase
`default_nettype wire

// *** hw/auto_restart_sequencer.sv ***
// Automatic fault acknowledgement and restart sequencer for the inverter.
`include "auto_restart_cfg.svh"
`default_nettype none
module auto_restart_sequencer
  import auto_restart_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = `ARS_TENTH_CYCLES
)
(
  // Clock and reset.
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  // Settings write port and readback.
  input  wire logic cfg_wr_i,
  input  wire cfg_s cfg_wdata_i,
  output cfg_s      cfg_o,
  output logic      cfg_reject_o,
  // Run command and drive status.
  input  wire logic run_command_i,
  input  wire logic fault_i,
  input  wire logic fault_ack_i,
  input  wire logic flying_done_i,
  input  wire logic magnetized_flag_i,
  // Sequencer actions.
  output logic      auto_ack_o,
  output logic      switch_on_o,
  output logic      restart_failed_fault_o,
  output logic      start_success_o,
  // Status.
  output status_s   status_o
);

  // Mode is one of the accepted codes.
  function automatic logic mode_ok(input logic [7:0] m);
    mode_ok = (m == `ARS_MODE_OFF) || (m == `ARS_MODE_ACK_ONLY) ||
              (m == `ARS_MODE_PF_RESTART) || (m == `ARS_MODE_FLT_RESTART) ||
              (m == `ARS_MODE_PF_MANUAL) || (m == `ARS_MODE_FLT_MANUAL) ||
              (m == `ARS_MODE_ACK_ALL_ON);
  endfunction : mode_ok

  // Mode switches the motor on again by itself.
  function automatic logic mode_restarts(input logic [7:0] m);
    mode_restarts = (m == `ARS_MODE_PF_RESTART) ||
                    (m == `ARS_MODE_FLT_RESTART) ||
                    (m == `ARS_MODE_PF_MANUAL) ||
                    (m == `ARS_MODE_FLT_MANUAL) ||
                    (m == `ARS_MODE_ACK_ALL_ON);
  endfunction : mode_restarts

  // Mode inserts the start wait time.
  function automatic logic mode_waits(input logic [7:0] m);
    mode_waits = (m == `ARS_MODE_PF_RESTART) ||
                 (m == `ARS_MODE_FLT_RESTART) ||
                 (m == `ARS_MODE_ACK_ALL_ON);
  endfunction : mode_waits

  // Mode may acknowledge a fault itself; modes 4 and 6 only given the run command.
  function automatic logic ack_allowed(input logic [7:0] m,
                                       input logic       run);
    ack_allowed = (m == `ARS_MODE_ACK_ONLY) ||
                  (m == `ARS_MODE_ACK_ALL_ON) ||
                  (run && ((m == `ARS_MODE_PF_RESTART) ||
                           (m == `ARS_MODE_FLT_RESTART)));
  endfunction : ack_allowed

  // Stored settings.
  cfg_s        cfg_r;
  // Sequencer state and its next value.
  seq_state_e  state_r;
  seq_state_e  state_nxt;
  // Start attempt counter.
  logic [7:0]  attempts_r;
  // A zero count has already granted its one extra attempt.
  logic        spent_r;
  // Tenth-second interval counter for wait and confirmation.
  logic [15:0] tenth_cnt_r;
  // Seconds counter of the restart monitor.
  logic [15:0] mon_cnt_r;
  logic        mon_run_r;
  // Seconds counter of the counter-reset monitor.
  logic [15:0] rst_cnt_r;
  // Ticks from the timebase.
  logic        tick_tenth;
  logic        tick_sec;
  // Decoded events.
  logic        restart_mode;
  logic        do_ack;
  logic        success;
  logic        mon_expire;
  logic        cnt_reload;
  logic        fail_set;
  logic        cfg_changed;
  logic        wait_done;

  // One free timebase serves every interval in the block.
  ars_timebase #(
    .TENTH_CYCLES (TENTH_CYCLES)
  ) u_timebase (
    .sys_clk_i    (sys_clk_i),
    .arst_n_i     (arst_n_i),
    .tick_tenth_o (tick_tenth),
    .tick_sec_o   (tick_sec)
  );

  assign restart_mode = mode_restarts(cfg_r.mode);

  // A write reloads the counter only when mode or limit really changes.
  assign cfg_changed = cfg_wr_i && mode_ok(cfg_wdata_i.mode) &&
                       ((cfg_wdata_i.mode != cfg_r.mode) ||
                        (cfg_wdata_i.limit != cfg_r.limit));

  // Settings store; an unknown mode code refuses the whole write.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_r.mode        <= `ARS_RST_MODE;
      cfg_r.limit       <= `ARS_RST_LIMIT;
      cfg_r.wait_tenths <= `ARS_RST_WAIT_TENTHS;
      cfg_r.mon_sec     <= `ARS_RST_MON_SEC;
      cfg_r.cnt_rst_sec <= `ARS_RST_CNT_RST_SEC;
      cfg_reject_o      <= 1'b0;
    end
    else
    begin
      cfg_reject_o <= cfg_wr_i && !mode_ok(cfg_wdata_i.mode);
      if (cfg_wr_i && mode_ok(cfg_wdata_i.mode))
      begin
        cfg_r <= cfg_wdata_i;
      end
    end
  end

  // The sequence acknowledges in the ACK state when the mode allows it,
  // or takes the outside acknowledgement in any mode.
  assign do_ack = (state_r == ST_ACK) &&
                  (ack_allowed(cfg_r.mode, run_command_i) ||
                   fault_ack_i);

  // The wait time is skipped in modes that do not use it.
  assign wait_done = !mode_waits(cfg_r.mode) ||
                     (tenth_cnt_r >= cfg_r.wait_tenths);

  // Success after the clean confirmation second with no new fault.
  assign success = (state_r == ST_CONFIRM) && !fault_i &&
                   (tenth_cnt_r >= `ARS_CONFIRM_TENTHS);

  // Monitor expiry; a zero setting switches the monitor off.
  assign mon_expire = mon_run_r && (cfg_r.mon_sec != 16'h0000) &&
                      (mon_cnt_r >= cfg_r.mon_sec);

  // Exhausted attempts or monitor expiry raise the failed fault.
  assign fail_set = (restart_mode && mon_expire) ||
                    ((state_r == ST_ACK) && do_ack && restart_mode &&
                     (attempts_r == 8'h00) && spent_r);

  // Counter reload after a clean run for the reset monitor time.
  assign cnt_reload = (state_r == ST_RUN) &&
                      (rst_cnt_r >= cfg_r.cnt_rst_sec);

  // Next-state decision of the restart sequence.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      // Waiting for a fault in a mode that reacts to it.
      ST_IDLE:
      begin
        if (fault_i && (cfg_r.mode != `ARS_MODE_OFF))
        begin
          state_nxt = ST_ACK;
        end
      end
      // Fault pending until acknowledged by the block or from outside.
      ST_ACK:
      begin
        if (fail_set)
        begin
          state_nxt = ST_FAILED;
        end
        else if (do_ack)
        begin
          state_nxt = restart_mode ? ST_WAIT : ST_IDLE;
        end
      end
      // Start wait time runs before every attempt in modes 4, 6 and 26.
      ST_WAIT:
      begin
        if (fail_set)
        begin
          state_nxt = ST_FAILED;
        end
        else if (fault_i)
        begin
          state_nxt = ST_ACK;
        end
        else if (wait_done && run_command_i)
        begin
          state_nxt = ST_START;
        end
      end
      // Motor switched on; wait for flying restart and magnetization.
      ST_START:
      begin
        if (fail_set)
        begin
          state_nxt = ST_FAILED;
        end
        else if (fault_i)
        begin
          state_nxt = ST_ACK;
        end
        else if (!run_command_i)
        begin
          state_nxt = ST_WAIT;
        end
        else if (flying_done_i && magnetized_flag_i)
        begin
          state_nxt = ST_CONFIRM;
        end
      end
      // One fault-free second confirms the attempt.
      ST_CONFIRM:
      begin
        if (fail_set)
        begin
          state_nxt = ST_FAILED;
        end
        else if (fault_i)
        begin
          state_nxt = ST_ACK;
        end
        else if (success)
        begin
          state_nxt = ST_RUN;
        end
      end
      // Running; a fault restarts the sequence with the reduced count.
      ST_RUN:
      begin
        if (fault_i)
        begin
          state_nxt = ST_ACK;
        end
        else if (cnt_reload)
        begin
          state_nxt = ST_IDLE;
        end
      end
      // Failed fault stands until run is off and it is acknowledged.
      ST_FAILED:
      begin
        if (!run_command_i && fault_ack_i)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    // A mode or limit change restarts the whole sequence from rest, except in ST_FAILED.
    if (cfg_changed && (state_r != ST_FAILED))
    begin
      state_nxt = ST_IDLE;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Start attempt counter: reload wins over a decrement in the same cycle.
  // The counter alone cannot tell the last grant at zero from the refusal
  // after it, so a flag marks that the extra attempt of n+1 was used.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      attempts_r <= `ARS_RST_LIMIT;
      spent_r    <= 1'b0;
    end
    else if (cfg_changed)
    begin
      attempts_r <= cfg_wdata_i.limit;
      spent_r    <= 1'b0;
    end
    else if (state_r == ST_FAILED && !run_command_i && fault_ack_i)
    begin
      attempts_r <= cfg_r.limit;
      spent_r    <= 1'b0;
    end
    else if (cnt_reload)
    begin
      attempts_r <= cfg_r.limit;
      spent_r    <= 1'b0;
    end
    else if (do_ack && restart_mode && attempts_r != 8'h00)
    begin
      attempts_r <= attempts_r - 8'h01;
    end
    else if (do_ack && restart_mode)
    begin
      spent_r <= 1'b1;
    end
  end

  // Tenth counter; cleared on each state change so each interval is fresh.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tenth_cnt_r <= 16'h0000;
    end
    else if (state_nxt != state_r)
    begin
      tenth_cnt_r <= 16'h0000;
    end
    else if (tick_tenth && tenth_cnt_r != 16'hFFFF)
    begin
      tenth_cnt_r <= tenth_cnt_r + 16'h0001;
    end
  end

  // Restart monitor: runs from fault to success or failure.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mon_run_r <= 1'b0;
      mon_cnt_r <= 16'h0000;
    end
    else if (success || state_nxt == ST_FAILED || state_nxt == ST_IDLE)
    begin
      mon_run_r <= 1'b0;
      mon_cnt_r <= 16'h0000;
    end
    else if (state_r != ST_ACK && state_nxt == ST_ACK && !mon_run_r)
    begin
      mon_run_r <= restart_mode;
      mon_cnt_r <= 16'h0000;
    end
    else if (mon_run_r && tick_sec && mon_cnt_r != 16'hFFFF)
    begin
      mon_cnt_r <= mon_cnt_r + 16'h0001;
    end
  end

  // Counter-reset monitor: counts seconds of clean running.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_cnt_r <= 16'h0000;
    end
    else if (state_r != ST_RUN)
    begin
      rst_cnt_r <= 16'h0000;
    end
    else if (tick_sec && rst_cnt_r != 16'hFFFF)
    begin
      rst_cnt_r <= rst_cnt_r + 16'h0001;
    end
  end

  // Registered action outputs; the failed flag set wins over its clear.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      auto_ack_o             <= 1'b0;
      switch_on_o            <= 1'b0;
      start_success_o        <= 1'b0;
      restart_failed_fault_o <= 1'b0;
    end
    else
    begin
      auto_ack_o      <= (state_r == ST_ACK) && !fail_set &&
                         ack_allowed(cfg_r.mode, run_command_i);
      switch_on_o     <= (state_nxt == ST_START) ||
                         (state_nxt == ST_CONFIRM) ||
                         (state_nxt == ST_RUN);
      start_success_o <= success;
      if (fail_set)
      begin
        restart_failed_fault_o <= 1'b1;
      end
      else if (!run_command_i && fault_ack_i)
      begin
        restart_failed_fault_o <= 1'b0;
      end
    end
  end

  // Readback and status.
  assign cfg_o                  = cfg_r;
  assign status_o.state         = state_r;
  assign status_o.attempts_left = attempts_r;
  assign status_o.mode_valid    = mode_ok(cfg_r.mode);
  assign status_o.monitor_run   = mon_run_r;

endmodule : auto_restart_sequencer
`default_nettype wire

// *** tb/drive_model.sv ***
// Behavioural drive core: flying restart then magnetization after switch-on.
`default_nettype none
module drive_model #(
  parameter int unsigned DELAY = 5  // Cycles for each drive phase.
)
(
  // Clock and reset.
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  // Switch-on request and drive status back to the sequencer.
  input  wire logic switch_on_i,
  output logic      flying_done_o,
  output logic      magnetized_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned on_cnt_r;  // Cycles since the request rose.

  // The status flags drop at once when the request goes away, as a real
  // drive loses magnetization with the pulses off.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      on_cnt_r <= 0;
    else if (!switch_on_i)
      on_cnt_r <= 0;
    else if (on_cnt_r < 2 * DELAY)
      on_cnt_r <= on_cnt_r + 1;
  end

  assign flying_done_o     = switch_on_i && (on_cnt_r >= DELAY);
  assign magnetized_flag_o = switch_on_i && (on_cnt_r >= 2 * DELAY);
endmodule : drive_model
`default_nettype wire

// *** tb/auto_restart_assertions.sv ***
// Port-level checker for the automatic restart sequencer.
`default_nettype none
module auto_restart_checker
  import auto_restart_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = 10
)
(
  // Clock and reset.
  input wire logic    sys_clk_i,
  input wire logic    arst_n_i,
  // Settings.
  input wire logic    cfg_wr_i,
  input wire cfg_s    cfg_wdata_i,
  input wire cfg_s    cfg_o,
  input wire logic    cfg_reject_o,
  // Commands and actions.
  input wire logic    run_command_i,
  input wire logic    fault_ack_i,
  input wire logic    auto_ack_o,
  input wire logic    switch_on_o,
  input wire logic    restart_failed_fault_o,
  input wire logic    start_success_o,
  input wire status_s status_o
);
  logic        rs_mode;     // Stored mode uses the attempt limit.
  logic        wr_valid;    // Written mode is a known code.
  int unsigned conf_cnt_r;  // Cycles spent confirming the present attempt.

  assign rs_mode  = cfg_o.mode inside {8'h04, 8'h06, 8'h0E, 8'h10, 8'h1A};
  assign wr_valid = cfg_wdata_i.mode inside
    {8'h00, 8'h01, 8'h04, 8'h06, 8'h0E, 8'h10, 8'h1A};

  // Every new attempt passes through acknowledgement, so that clears the count.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      conf_cnt_r <= 0;
    else if (status_o.state == ST_ACK)
      conf_cnt_r <= 0;
    else if (status_o.state == ST_CONFIRM)
      conf_cnt_r <= conf_cnt_r + 1;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  always_ack_a: assert property (status_o.state == ST_ACK &&
    cfg_o.mode inside {8'h01, 8'h1A} |=>
    auto_ack_o != restart_failed_fault_o)
    else $error("No self acknowledgement in an always mode.");
  ack_run_a: assert property (auto_ack_o &&
    $past(cfg_o.mode) inside {8'h04, 8'h06} |-> $past(run_command_i))
    else $error("Self acknowledgement without run command.");
  no_self_ack_a: assert property (
    $past(cfg_o.mode) inside {8'h0E, 8'h10} |-> !auto_ack_o)
    else $error("Self acknowledgement in a manual mode.");
  switch_run_a: assert property ($rose(switch_on_o) |->
    $past(run_command_i) && $past(cfg_o.mode) != 8'h01)
    else $error("Switch-on without run command or in mode 1.");
  confirm_sec_a: assert property (start_success_o |->
    conf_cnt_r >= 9 * TENTH_CYCLES)
    else $error("Start declared good before the clean second.");
  ack_count_a: assert property (auto_ack_o && rs_mode &&
    $past(status_o.attempts_left) != 8'h00 |-> status_o.attempts_left ==
    $past(status_o.attempts_left) - 8'h01)
    else $error("Acknowledgement did not decrement the counter.");
  cfg_reload_a: assert property (cfg_wr_i && wr_valid &&
    (cfg_wdata_i.mode != cfg_o.mode || cfg_wdata_i.limit != cfg_o.limit)
    |=> status_o.attempts_left == $past(cfg_wdata_i.limit))
    else $error("Counter not reloaded on a settings change.");
  bad_mode_a: assert property (cfg_wr_i && !wr_valid |=>
    ##[0:1] cfg_reject_o ##0 $stable(cfg_o))
    else $error("Invalid mode write was not refused.");
  failed_hold_a: assert property (restart_failed_fault_o &&
    (run_command_i || !fault_ack_i) |=> restart_failed_fault_o)
    else $error("Failed fault cleared without both conditions.");

  success_c: cover property (start_success_o);
  failed_c: cover property ($rose(restart_failed_fault_o));
  reject_c: cover property (cfg_reject_o);
endmodule : auto_restart_checker

bind auto_restart_sequencer auto_restart_checker #(
  .TENTH_CYCLES(TENTH_CYCLES)
) chk (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cfg_wr_i(cfg_wr_i),
  .cfg_wdata_i(cfg_wdata_i), .cfg_o(cfg_o), .cfg_reject_o(cfg_reject_o),
  .run_command_i(run_command_i), .fault_ack_i(fault_ack_i),
  .auto_ack_o(auto_ack_o), .switch_on_o(switch_on_o),
  .restart_failed_fault_o(restart_failed_fault_o),
  .start_success_o(start_success_o), .status_o(status_o)
);
`default_nettype wire

// *** tb/tb_auto_restart_sequencer.sv ***
// Self-checking testbench for the automatic restart sequencer.
`default_nettype none
module tb_auto_restart_sequencer
  import auto_restart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic    sys_clk_i, arst_n_i, cfg_wr_i, run_command_i, fault_i, fault_ack_i;
  logic    flying_done_i, magnetized_flag_i, hit;
  cfg_s    cfg_wdata_i, cfg_o;
  status_s status_o;
  logic    cfg_reject_o, auto_ack_o, switch_on_o, restart_failed_fault_o;
  logic    start_success_o;
  logic [4:0] outs;  // Action outputs, indexed by the wait helper.
  int      err_count, compares, cyc, n;
  logic [7:0] modes [7] = '{8'h00, 8'h01, 8'h04, 8'h06, 8'h0E, 8'h10, 8'h1A};

  assign outs = {cfg_reject_o, restart_failed_fault_o, start_success_o,
                 switch_on_o, auto_ack_o};

  // A short tenth keeps a whole second at 100 cycles.
  auto_restart_sequencer #(.TENTH_CYCLES(10)) dut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cfg_wr_i(cfg_wr_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_o(cfg_o), .cfg_reject_o(cfg_reject_o),
    .run_command_i(run_command_i), .fault_i(fault_i),
    .fault_ack_i(fault_ack_i), .flying_done_i(flying_done_i),
    .magnetized_flag_i(magnetized_flag_i), .auto_ack_o(auto_ack_o),
    .switch_on_o(switch_on_o),
    .restart_failed_fault_o(restart_failed_fault_o),
    .start_success_o(start_success_o), .status_o(status_o));

  // The drive core answers every switch-on request.
  drive_model #(.DELAY(5)) drive (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .switch_on_i(switch_on_o),
    .flying_done_o(flying_done_i), .magnetized_flag_o(magnetized_flag_i));

  // Prints the counts and the verdict, then stops the run.
  task automatic final_report();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // Compares one observed value with its expectation.
  task automatic check(input string name, input logic [63:0] seen,
                       input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // Writes all settings in one strobe, as the port takes them together.
  task automatic write_cfg(input logic [7:0] m, input logic [7:0] l,
                           input logic [15:0] w);
    @(negedge sys_clk_i);
    cfg_wdata_i = {m, l, w, 16'h003C, 16'h0000};
    cfg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    cfg_wr_i = 1'b0;
  endtask : write_cfg

  // One-cycle pulse: 0 is a fault event, anything else an acknowledgement.
  task automatic pulse(input int sel);
    @(negedge sys_clk_i);
    if (sel == 0)
      fault_i = 1'b1;
    else
      fault_ack_i = 1'b1;
    @(negedge sys_clk_i);
    fault_i = 1'b0;
    fault_ack_i = 1'b0;
  endtask : pulse

  // Watches one action output for a bounded number of cycles.
  task automatic wait_out(input int sel, input int lim, output logic h);
    int i;
    h = 1'b0;
    for (i = 0; i < lim && !h; i++)
    begin
      @(negedge sys_clk_i);
      h = (outs[sel] === 1'b1);
    end
  endtask : wait_out

  // Free-running clock.
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // A hang counts as a mismatch; the tests need under 1000 cycles.
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  // Main sequence.
  initial
  begin
    arst_n_i = 1'b0;
    cfg_wr_i = 1'b0;
    cfg_wdata_i = '0;
    run_command_i = 1'b0;
    fault_i = 1'b0;
    fault_ack_i = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    check("cfg", cfg_o, {8'h00, 8'h03, 16'h000A, 16'h003C, 16'h0000});
    check("left", status_o.attempts_left, 8'h03);
    write_cfg(8'h02, 8'h05, 16'h0001);
    check("reject", cfg_reject_o, 1'b1);
    check("mode", cfg_o.mode, 8'h00);
    check("valid", status_o.mode_valid, 1'b1);
    foreach (modes[i])
    begin
      write_cfg(modes[i], 8'h03, 16'h0003);
      check("mode", cfg_o.mode, modes[i]);
    end
    // Mode 26 with a three-tenth wait and an immediate counter reload.
    run_command_i = 1'b1;
    pulse(0);
    wait_out(0, 5, hit);
    check("ack26", hit, 1'b1);
    check("left", status_o.attempts_left, 8'h02);
    check("monrun", status_o.monitor_run, 1'b1);
    wait_out(1, 15, hit);
    check("early", hit, 1'b0);
    wait_out(1, 30, hit);
    check("switch", hit, 1'b1);
    wait_out(2, 200, hit);
    check("success", hit, 1'b1);
    repeat (3) @(negedge sys_clk_i);
    check("left", status_o.attempts_left, 8'h03);
    check("monrun", status_o.monitor_run, 1'b0);
    // Mode 14 waits for an outside acknowledgement and applies no wait.
    write_cfg(8'h0E, 8'h03, 16'h0003);
    pulse(0);
    wait_out(0, 20, hit);
    check("ack14", hit, 1'b0);
    pulse(1);
    wait_out(1, 12, hit);
    check("nowait", hit, 1'b1);
    wait_out(2, 200, hit);
    check("success", hit, 1'b1);
    // Mode 4 acknowledges only once the run command is present.
    write_cfg(8'h04, 8'h03, 16'h0003);
    run_command_i = 1'b0;
    pulse(0);
    wait_out(0, 20, hit);
    check("ack4lo", hit, 1'b0);
    run_command_i = 1'b1;
    wait_out(0, 5, hit);
    check("ack4hi", hit, 1'b1);
    wait_out(2, 300, hit);
    check("success", hit, 1'b1);
    // Mode 1 acknowledges but never switches on.
    write_cfg(8'h01, 8'h03, 16'h0003);
    pulse(0);
    wait_out(0, 5, hit);
    check("ack1", hit, 1'b1);
    wait_out(1, 60, hit);
    check("noswitch", hit, 1'b0);
    // Limit 1: every attempt is broken in confirmation until failure.
    write_cfg(8'h1A, 8'h01, 16'h0001);
    check("left", status_o.attempts_left, 8'h01);
    n = 0;
    for (int i = 0; i < 4 && restart_failed_fault_o !== 1'b1; i++)
    begin
      pulse(0);
      repeat (3) @(negedge sys_clk_i);
      wait_out(1, 40, hit);
      if (hit)
        n++;
      repeat (20) @(negedge sys_clk_i);
    end
    check("attempts", n, 2);
    check("failed", restart_failed_fault_o, 1'b1);
    check("state", status_o.state, ST_FAILED);
    pulse(1);
    repeat (2) @(negedge sys_clk_i);
    check("failed", restart_failed_fault_o, 1'b1);
    run_command_i = 1'b0;
    pulse(1);
    repeat (2) @(negedge sys_clk_i);
    check("failed", restart_failed_fault_o, 1'b0);
    check("left", status_o.attempts_left, 8'h01);
    check("state", status_o.state, ST_IDLE);
    final_report();
  end
endmodule : tb_auto_restart_sequencer
`default_nettype wire
